//--- sim/pps_plant_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Plant model: pressure sensor, pressure switch, tank float, pump faults.
// ----------------------------------------------------------------------
module pps_plant_model (
	output logic [7:0] pressure,
	output logic       tank_low,
	output logic       press_sw_closed,
	output logic [1:0] pump_fault
);
	logic [7:0] p_q     = 8'h28;
	logic       sw_q    = 1'b1;
	logic       tank_q  = 1'b0;
	logic [1:0] fault_q = 2'h0;

	// The bench sets these levels just after a falling edge, so they settle early.
	assign pressure        = p_q;
	assign press_sw_closed = sw_q;
	assign tank_low        = tank_q;
	assign pump_fault      = fault_q;
endmodule

//--- sim/pps_supervisor_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker of the pump pressure supervisor.
// ----------------------------------------------------------------------
module pps_supervisor_monitor #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic [7:0]  pressure,
	input wire logic [7:0]  over_thr,
	input wire logic        under_react_off,
	input wire logic        two_pumps,
	input wire logic [1:0]  pump_mode,
	input wire logic [1:0]  valve1_mode,
	input wire logic        tank_low,
	input wire logic        press_sw_closed,
	input wire logic [1:0]  pump_fault,
	input wire logic [1:0]  manual_hold,
	input wire logic [1:0]  pump_run,
	input wire logic [1:0]  valve_fresh,
	input wire logic        fault_lamp,
	input wire logic        collective_fault_output,
	input wire logic        dry_run_out_closed,
	input wire logic [3:0]  err_code,
	input wire logic        err_reset_avail,
	input wire logic [15:0] dry_run_count
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	// Alarm states held over two samples.
	sequence s_over_held;
		err_code == pps_pkg::ERR_OVER ##1 err_code == pps_pkg::ERR_OVER;
	endsequence
	sequence s_dry_open;
		!dry_run_out_closed ##1 !dry_run_out_closed;
	endsequence

	property p_over_cause;
		$rose(err_code == pps_pkg::ERR_OVER) |-> $past(pressure > over_thr, 3);
	endproperty
	property p_over_stop;
		s_over_held |-> pump_run == 2'h0 && fault_lamp;
	endproperty
	property p_lamp_pair;
		fault_lamp == collective_fault_output;
	endproperty
	property p_under_cont;
		err_code == pps_pkg::ERR_UNDER && !under_react_off |-> !fault_lamp;
	endproperty
	property p_dry_stop;
		s_dry_open |-> pump_run == 2'h0;
	endproperty
	property p_sw_closed;
		$past(nrst) && press_sw_closed |=> dry_run_out_closed;
	endproperty
	property p_dry_count;
		$rose(tank_low) |=> dry_run_count == $past(dry_run_count) + 16'h0001;
	endproperty
	property p_valve;
		valve1_mode == pps_pkg::VALVE_FRESH || (valve1_mode == pps_pkg::VALVE_AUTO && tank_low)
			|=> valve_fresh[0];
	endproperty
	property p_manual;
		(manual_hold[0] && !pump_fault[0] && err_code == pps_pkg::ERR_NONE)
			##1 err_code == pps_pkg::ERR_NONE |-> pump_run[0];
	endproperty
	property p_pump_off;
		!two_pumps || (pump_mode[1] == pps_pkg::PUMP_OFF && !manual_hold[1]) |=> !pump_run[1];
	endproperty
	property p_reset_avail;
		err_reset_avail == (err_code != pps_pkg::ERR_NONE);
	endproperty

	a_over_cause: assert property (p_over_cause) else $error("over alarm without cause");
	a_over_stop: assert property (p_over_stop) else $error("over alarm left pumps on");
	a_lamp_pair: assert property (p_lamp_pair) else $error("lamp and fault output differ");
	a_under_cont: assert property (p_under_cont) else $error("continue reaction lit lamp");
	a_dry_stop: assert property (p_dry_stop) else $error("dry run left pumps on");
	a_sw_closed: assert property (p_sw_closed) else $error("dry output open on closed switch");
	a_dry_count: assert property (p_dry_count) else $error("dry run counter missed");
	a_valve: assert property (p_valve) else $error("valve not at fresh");
	a_manual: assert property (p_manual) else $error("held pump not running");
	a_pump_off: assert property (p_pump_off) else $error("pump two running while off");
	a_reset_avail: assert property (p_reset_avail) else $error("reset offer wrong");
endmodule

bind pps_supervisor pps_supervisor_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.mclk(mclk), .nrst(nrst), .pressure(pressure), .over_thr(over_thr),
	.under_react_off(under_react_off), .two_pumps(two_pumps), .pump_mode(pump_mode),
	.valve1_mode(valve1_mode), .tank_low(tank_low), .press_sw_closed(press_sw_closed),
	.pump_fault(pump_fault),
	.manual_hold(manual_hold), .pump_run(pump_run), .valve_fresh(valve_fresh),
	.fault_lamp(fault_lamp), .collective_fault_output(collective_fault_output),
	.dry_run_out_closed(dry_run_out_closed), .err_code(err_code),
	.err_reset_avail(err_reset_avail), .dry_run_count(dry_run_count));

//--- sim/pump_pressure_supervisor_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Self-checking bench of the pump pressure supervisor.
// ----------------------------------------------------------------------
module pump_pressure_supervisor_tb;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  over_thr = pps_pkg::OVER_THR_DEF;
	logic [7:0]  under_thr = pps_pkg::UNDER_THR_DEF;
	logic        react_off = 1'b0;
	logic        demand_base = 1'b0;
	logic        demand_peak = 1'b0;
	logic        standby_en = 1'b0;
	logic        err_reset = 1'b0;
	logic [1:0]  pump_mode = 2'h3;
	logic [1:0]  valve1_mode = pps_pkg::VALVE_AUTO;
	logic [1:0]  manual_hold = 2'h0;
	logic [7:0]  pressure;
	logic        tank_low, press_sw_closed, fault_lamp, coll_fault, dry_out, avail, base;
	logic [1:0]  pump_fault, pump_run, valve_fresh;
	logic [3:0]  err_code, code_seen = 4'h0;
	logic [15:0] dry_cnt, cnt_seen = 16'h0000, cnt_exp = 16'h0000;
	logic [3:0]  code_q[$];
	logic [15:0] cnt_q[$];
	int          bad_count = 0;
	int          checks = 0;
	int          m;

	pps_plant_model plant (.pressure(pressure), .tank_low(tank_low),
		.press_sw_closed(press_sw_closed), .pump_fault(pump_fault));
	pps_supervisor #(.TICK_CYCLES(10)) uut (.mclk(mclk), .nrst(nrst), .pressure(pressure),
		.over_thr(over_thr), .under_thr(under_thr), .detect_delay_s(8'h02),
		.dry_delay_s(8'h03), .under_react_off(react_off), .cycling_en(1'b0),
		.standby_en(standby_en), .two_pumps(1'b1), .pump_mode(pump_mode),
		.valve1_mode(valve1_mode), .valve2_mode(pps_pkg::VALVE_AUTO),
		.demand_base(demand_base), .demand_peak(demand_peak),
		.tank_low(tank_low), .press_sw_closed(press_sw_closed), .pump_fault(pump_fault),
		.manual_hold(manual_hold), .err_reset(err_reset), .pump_run(pump_run),
		.valve_fresh(valve_fresh), .fault_lamp(fault_lamp), .collective_fault_output(coll_fault),
		.dry_run_out_closed(dry_out), .err_code(err_code), .err_reset_avail(avail),
		.dry_run_count(dry_cnt), .base_pump(base));

	// Clock of 100 ns period.
	always #50 mclk = ~mclk;

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Waits a bounded time for every noted result to show up.
	task automatic settle(input int n);
		int i;
		for (i = 0; i < n && code_q.size() + cnt_q.size() > 0; i++)
			cyc(1);
		cmp("pending results", 16'h0000, 16'(code_q.size() + cnt_q.size()));
		code_q.delete();
		cnt_q.delete();
	endtask

	// Each change of error code or counter is matched to the oldest note.
	always @(negedge mclk)
	begin
		if (nrst && err_code !== code_seen)
		begin
			cmp("err_code", code_q.size() ? 16'(code_q.pop_front()) : 16'h00FF, 16'(err_code));
			code_seen = err_code;
		end
		if (nrst && dry_cnt !== cnt_seen)
		begin
			cmp("dry_run_count", cnt_q.size() ? cnt_q.pop_front() : 16'hFFFF, dry_cnt);
			cnt_seen = dry_cnt;
		end
	end

	// Watchdog over the whole run.
	initial
	begin
		#3000000;
		bad_count++;
		end_sim();
	end

	// Main sequence.
	initial
	begin
		void'($urandom(86764));
		cyc(12);
		nrst = 1'b1;
		cyc(4);
		plant.p_q = 8'h51;
		cyc(8);
		plant.p_q = 8'h28;
		demand_base = 1'b1;
		cyc(40);
		plant.p_q = 8'h51 + 8'($urandom % 48);
		code_q.push_back(pps_pkg::ERR_OVER);
		settle(60);
		cyc(2);
		cmp("pump_run", 16'h0000, 16'(pump_run));
		cmp("fault_lamp", 16'h0001, 16'({fault_lamp, coll_fault} == 2'b11));
		plant.p_q = over_thr;
		code_q.push_back(pps_pkg::ERR_NONE);
		settle(60);
		demand_base = 1'b0;
		cyc(4);
		plant.p_q = 8'h05;
		cyc(50);
		demand_base = 1'b1;
		code_q.push_back(pps_pkg::ERR_UNDER);
		settle(60);
		cmp("continue", 16'h0001, 16'(!fault_lamp && pump_run != 2'h0));
		plant.p_q = under_thr;
		code_q.push_back(pps_pkg::ERR_NONE);
		settle(60);
		react_off = 1'b1;
		plant.p_q = 8'h05;
		code_q.push_back(pps_pkg::ERR_UNDER);
		settle(60);
		cyc(2);
		cmp("off reaction", 16'h0007, 16'({pump_run == 2'h0, fault_lamp, avail}));
		plant.p_q = 8'h28;
		cyc(60);
		code_q.push_back(pps_pkg::ERR_NONE);
		err_reset = 1'b1;
		cyc(1);
		err_reset = 1'b0;
		settle(10);
		cmp("reset offer", 16'h0000, 16'(avail));
		react_off = 1'b0;
		under_thr = pps_pkg::UNDER_OFF_THR;
		plant.p_q = 8'h00;
		cyc(60);
		plant.p_q = 8'h28;
		cyc(2);
		under_thr = pps_pkg::UNDER_THR_DEF;
		plant.sw_q = 1'b0;
		cyc(15);
		plant.sw_q = 1'b1;
		cyc(40);
		plant.sw_q = 1'b0;
		code_q.push_back(pps_pkg::ERR_DRY);
		settle(60);
		cmp("dry stop", 16'h0003, 16'({dry_out, pump_run == 2'h0, fault_lamp}));
		plant.sw_q = 1'b1;
		code_q.push_back(pps_pkg::ERR_NONE);
		settle(10);
		for (m = 0; m < 8; m++)
		begin
			valve1_mode = 2'(m / 2);
			plant.tank_q = m[0];
			if (m[0])
			begin
				cnt_exp++;
				cnt_q.push_back(cnt_exp);
			end
			cyc(3);
			cmp("valve_fresh", 16'({m[0], m / 2 == 1 || (m / 2 == 2 && m[0])}), 16'(valve_fresh));
			plant.tank_q = 1'b0;
			cyc(2);
		end
		settle(5);
		demand_base = 1'b0;
		pump_mode = {2{pps_pkg::PUMP_OFF}};
		plant.fault_q = 2'h2;
		manual_hold = 2'h3;
		cyc(3);
		cmp("manual run", 16'h0001, 16'(pump_run));
		manual_hold = 2'h0;
		cyc(3);
		cmp("manual release", 16'h0000, 16'(pump_run));
		plant.fault_q = 2'h0;
		pump_mode = {2{pps_pkg::PUMP_AUTO}};
		demand_base = 1'b1;
		cyc(3);
		m = int'(base);
		demand_base = 1'b0;
		cyc(4);
		demand_base = 1'b1;
		cyc(3);
		cmp("base_pump", 16'(!m[0]), 16'(base));
		// Peak demand brings in the second pump unless it is the standby pump.
		demand_peak = 1'b1;
		cyc(3);
		cmp("peak run", 16'h0003, 16'(pump_run));
		standby_en = 1'b1;
		cyc(3);
		cmp("standby idle", 16'(m[0] ? 2'h1 : 2'h2), 16'(pump_run));
		plant.fault_q = m[0] ? 2'h1 : 2'h2;
		cyc(3);
		cmp("standby cover", 16'(m[0] ? 2'h2 : 2'h1), 16'(pump_run));
		end_sim();
	end
endmodule

//--- src/pps_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants of the pump pressure supervisor.
// ---------------------------------------------------------------------------
package pps_pkg;

	// Clock and timebase.
	localparam int CLK_PERIOD_NS = 100;
	localparam int SEC_NS        = 1000000000;
	localparam int TICK_CYCLES   = SEC_NS / CLK_PERIOD_NS;

	// Pressure is carried in tenths of a bar.
	localparam logic [7:0] OVER_THR_DEF  = 8'h50;
	localparam logic [7:0] UNDER_THR_DEF = 8'h0A;
	localparam logic [7:0] UNDER_OFF_THR = 8'h00;

	// Shared detection delay default, in seconds.
	localparam logic [7:0] DETECT_DELAY_S_DEF = 8'h05;

	// Auto-clear delay of the pressure alarms, in seconds.
	localparam logic [7:0] AUTO_CLEAR_S = 8'h02;

	// Periodic base-load swap interval.
	localparam int          CYCLE_TIME_H = 6;
	localparam int          SEC_PER_HOUR = 3600;
	localparam logic [14:0] CYCLE_S      = 15'(CYCLE_TIME_H * SEC_PER_HOUR);

	// Pump and valve mode encodings.
	localparam logic       PUMP_OFF   = 1'b0;
	localparam logic       PUMP_AUTO  = 1'b1;
	localparam logic [1:0] VALVE_RAIN  = 2'h0;
	localparam logic [1:0] VALVE_FRESH = 2'h1;
	localparam logic [1:0] VALVE_AUTO  = 2'h2;

	// Error codes.
	localparam logic [3:0] ERR_NONE  = 4'h0;
	localparam logic [3:0] ERR_OVER  = 4'h1;
	localparam logic [3:0] ERR_UNDER = 4'h2;
	localparam logic [3:0] ERR_DRY   = 4'h3;

	// Counter widths.
	localparam int TICK_W = 24;
	localparam int SEC_W  = 8;
	localparam int CYC_W  = 15;
	localparam int DRY_W  = 16;

endpackage

//--- src/pps_supervisor.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Overpressure is watched at all times.
// R2 - Overpressure alarm after threshold held for delay.
// R3 - Overpressure alarm switches off every pump.
// R4 - Overpressure shows code, lamp and collective fault.
// R5 - Overpressure clears itself shortly after pressure drops.
// R6 - Underpressure threshold zero disables underpressure watch.
// R7 - Underpressure judged only while a pump runs.
// R8 - Underpressure alarm after low pressure held for delay.
// R9 - Continue reaction: keep pumping, code only, auto-clear.
// R10 - Off reaction: stop pumps, lamp, fault, latched.
// R11 - Base-load role swaps at next activation after stop.
// R12 - Base-load pump swaps every six hours if enabled.
// R13 - Standby pump runs only when the other faults; the code also runs it when the other is in off mode.
// R14 - Standby pump still runs through cycling swaps.
// R15 - Tank low: auto-mode valves to fresh, count dry runs.
// R16 - Pressure-side dry run stops pumps, alarm, output opens.
// R17 - Contact reclosing before delay cancels the deactivation.
// R18 - Manual pump runs only while knob is held.
// R19 - Pump off/auto and valve rain/fresh/auto modes.
// R20 - Reset action offered only while an error exists.
// R21 - Pressure switch open stops pumps after set time.
// R22 - Auto-clear delay is a configurable constant.
module pps_supervisor #(
	parameter int TICK_CYCLES = pps_pkg::TICK_CYCLES
) (
	input  wire logic                      mclk,
	input  wire logic                      nrst,
	input  wire logic [7:0]                pressure,
	input  wire logic [7:0]                over_thr,
	input  wire logic [7:0]                under_thr,
	input  wire logic [7:0]                detect_delay_s,
	input  wire logic [7:0]                dry_delay_s,
	input  wire logic                      under_react_off,
	input  wire logic                      cycling_en,
	input  wire logic                      standby_en,
	input  wire logic                      two_pumps,
	input  wire logic [1:0]                pump_mode,
	input  wire logic [1:0]                valve1_mode,
	input  wire logic [1:0]                valve2_mode,
	input  wire logic                      demand_base,
	input  wire logic                      demand_peak,
	input  wire logic                      tank_low,
	input  wire logic                      press_sw_closed,
	input  wire logic [1:0]                pump_fault,
	input  wire logic [1:0]                manual_hold,
	input  wire logic                      err_reset,
	output logic      [1:0]                pump_run,
	output logic      [1:0]                valve_fresh,
	output logic                           fault_lamp,
	output logic                           collective_fault_output,
	output logic                           dry_run_out_closed,
	output logic      [3:0]                err_code,
	output logic                           err_reset_avail,
	output logic      [pps_pkg::DRY_W-1:0] dry_run_count,
	output logic                           base_pump
);

	// -----------------------------------------------------------------------
	// Functions
	// -----------------------------------------------------------------------

	// Decodes a valve mode into its position; auto follows the tank state.
	function automatic logic valve_pos(input logic [1:0] mode, input logic auto_fresh);
		logic pos;
		pos = 1'b0;
		case (mode)
			pps_pkg::VALVE_FRESH: pos = 1'b1;
			pps_pkg::VALVE_AUTO:  pos = auto_fresh;
			default:              pos = 1'b0;
		endcase
		return pos;
	endfunction

	// Saturating one-second step of a delay counter.
	function automatic logic [pps_pkg::SEC_W-1:0] sec_step(
		input logic [pps_pkg::SEC_W-1:0] cnt,
		input logic                      tick
	);
		logic [pps_pkg::SEC_W-1:0] nxt;
		nxt = cnt;
		if (tick && cnt != {pps_pkg::SEC_W{1'b1}})
			nxt = cnt + 1'b1;
		return nxt;
	endfunction

	// -----------------------------------------------------------------------
	// Timebase
	// -----------------------------------------------------------------------

	logic [pps_pkg::TICK_W-1:0] tick_cnt_q;
	logic [pps_pkg::TICK_W-1:0] tick_cnt_d;
	logic                       sec_tick_q;
	logic                       sec_tick_d;

	// Divides the clock down to a one-cycle pulse each second.
	always_comb
	begin
		tick_cnt_d = tick_cnt_q + 1'b1;
		sec_tick_d = 1'b0;
		if (tick_cnt_q == pps_pkg::TICK_W'(TICK_CYCLES - 1))
		begin
			tick_cnt_d = '0;
			sec_tick_d = 1'b1;
		end
	end

	// Registers the timebase.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			tick_cnt_q <= '0;
			sec_tick_q <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
			sec_tick_q <= sec_tick_d;
		end
	end

	// -----------------------------------------------------------------------
	// Alarms
	// -----------------------------------------------------------------------

	logic [pps_pkg::SEC_W-1:0] over_cnt_q, over_cnt_d;
	logic [pps_pkg::SEC_W-1:0] under_cnt_q, under_cnt_d;
	logic [pps_pkg::SEC_W-1:0] dry_cnt_q, dry_cnt_d;
	logic                      over_alarm_q, over_alarm_d;
	logic                      under_alarm_q, under_alarm_d;
	logic                      under_latch_q, under_latch_d;
	logic                      dry_alarm_q, dry_alarm_d;
	logic                      tank_low_q, tank_low_d;
	logic [pps_pkg::DRY_W-1:0] dry_count_q, dry_count_d;
	logic                      above_over;
	logic                      below_under;
	logic                      under_watch;

	assign above_over  = pressure > over_thr;
	assign below_under = pressure < under_thr;
	assign under_watch = (under_thr != pps_pkg::UNDER_OFF_THR) && (pump_run != 2'b00); // [R6] [R7]

	// Qualifies, latches and clears the pressure and dry-run alarms.
	always_comb
	begin
		over_cnt_d    = '0;
		under_cnt_d   = '0;
		dry_cnt_d     = '0;
		over_alarm_d  = over_alarm_q;
		under_alarm_d = under_alarm_q;
		under_latch_d = under_latch_q;
		dry_alarm_d   = dry_alarm_q;
		tank_low_d    = tank_low;
		dry_count_d   = dry_count_q;
		// Overpressure is judged regardless of pumps or settings.
		if (!over_alarm_q)
		begin
			if (above_over) // [R1]
				over_cnt_d = sec_step(over_cnt_q, sec_tick_q);
			if (above_over && over_cnt_q >= detect_delay_s)
				over_alarm_d = 1'b1; // [R2]
		end
		else if (!above_over)
		begin
			over_cnt_d = sec_step(over_cnt_q, sec_tick_q);
			if (over_cnt_q >= pps_pkg::AUTO_CLEAR_S)
				over_alarm_d = 1'b0; // [R5] [R22]
		end
		// Underpressure qualification and reaction.
		if (!under_alarm_q)
		begin
			if (under_watch && below_under)
				under_cnt_d = sec_step(under_cnt_q, sec_tick_q);
			if (under_watch && below_under && under_cnt_q >= detect_delay_s)
			begin
				under_alarm_d = 1'b1; // [R8]
				under_latch_d = under_react_off; // [R10]
			end
		end
		else if (under_latch_q)
		begin
			if (err_reset)
				under_alarm_d = 1'b0; // [R10]
		end
		else if (!below_under)
		begin
			under_cnt_d = sec_step(under_cnt_q, sec_tick_q);
			if (under_cnt_q >= pps_pkg::AUTO_CLEAR_S)
				under_alarm_d = 1'b0; // [R9] [R22]
		end
		// Pressure-side dry run; a reclosed contact cancels or resets it.
		if (press_sw_closed)
			dry_alarm_d = 1'b0; // [R17] [R21]
		else if (!dry_alarm_q)
		begin
			dry_cnt_d = sec_step(dry_cnt_q, sec_tick_q);
			if (dry_cnt_q >= dry_delay_s)
				dry_alarm_d = 1'b1; // [R16] [R21]
		end
		// Counts each fall of the tank below its dry-run level.
		if (tank_low && !tank_low_q)
			dry_count_d = dry_count_q + 1'b1; // [R15]
	end

	// Registers the alarm state.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			over_cnt_q    <= '0;
			under_cnt_q   <= '0;
			dry_cnt_q     <= '0;
			over_alarm_q  <= 1'b0;
			under_alarm_q <= 1'b0;
			under_latch_q <= 1'b0;
			dry_alarm_q   <= 1'b0;
			tank_low_q    <= 1'b0;
			dry_count_q   <= '0;
		end
		else
		begin
			over_cnt_q    <= over_cnt_d;
			under_cnt_q   <= under_cnt_d;
			dry_cnt_q     <= dry_cnt_d;
			over_alarm_q  <= over_alarm_d;
			under_alarm_q <= under_alarm_d;
			under_latch_q <= under_latch_d;
			dry_alarm_q   <= dry_alarm_d;
			tank_low_q    <= tank_low_d;
			dry_count_q   <= dry_count_d;
		end
	end

	// -----------------------------------------------------------------------
	// Pump and valve control
	// -----------------------------------------------------------------------

	logic                      base_q, base_d;
	logic                      off_seen_q, off_seen_d;
	logic [pps_pkg::CYC_W-1:0] cyc_cnt_q, cyc_cnt_d;
	logic [1:0]                run_q, run_d;
	logic [1:0]                valve_q, valve_d;
	logic [1:0]                avail;
	logic [1:0]                want;
	logic                      stop_all;
	logic                      lamp_d;
	logic [3:0]                code_d;

	// A pump is usable in automatic mode when present and not faulted.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_avail
			assign avail[gi] = (pump_mode[gi] == pps_pkg::PUMP_AUTO) && !pump_fault[gi]
				&& (gi == 0 || two_pumps); // [R19]
		end
	endgenerate

	assign stop_all = over_alarm_q || (under_alarm_q && under_latch_q) || dry_alarm_q;

	// Assigns pump roles, runs the pumps and positions the valves.
	always_comb
	begin
		base_d     = base_q;
		off_seen_d = off_seen_q;
		cyc_cnt_d  = cyc_cnt_q;
		want       = 2'b00;
		// Periodic base-load swap.
		if (cycling_en && two_pumps)
		begin
			if (sec_tick_q)
				cyc_cnt_d = cyc_cnt_q + 1'b1;
			if (cyc_cnt_q >= pps_pkg::CYCLE_S - 1'b1 && sec_tick_q)
			begin
				cyc_cnt_d = '0;
				base_d    = !base_q; // [R12] [R14]
			end
		end
		else
			cyc_cnt_d = '0;
		// Swap roles on the first demand after a full stop.
		if (run_q == 2'b00)
			off_seen_d = 1'b1;
		if (demand_base && off_seen_q && two_pumps)
		begin
			base_d     = !base_q; // [R11]
			off_seen_d = 1'b0;
		end
		// Demand by role; the standby pump only covers a partner that is faulted or in off mode.
		if (demand_base)
		begin
			if (avail[base_q])
				want[base_q] = 1'b1;
			else if (two_pumps && avail[!base_q])
				want[!base_q] = 1'b1; // [R13]
		end
		if (demand_peak && !standby_en && two_pumps && avail[!base_q])
			want[!base_q] = 1'b1; // [R13]
		// Held knob overrides the mode; release falls back to it.
		run_d = (want | manual_hold) & ~pump_fault; // [R18]
		if (!two_pumps)
			run_d[1] = 1'b0;
		if (stop_all)
			run_d = 2'b00; // [R3] [R10] [R16]
		// Valves in auto mode go to fresh water as soon as the tank runs low.
		valve_d[0] = valve_pos(valve1_mode, tank_low); // [R15] [R19]
		valve_d[1] = valve_pos(valve2_mode, tank_low); // [R15] [R19]
		// Fault lamp and code; continue-mode underpressure shows code only.
		lamp_d = stop_all; // [R4] [R10] [R9]
		code_d = pps_pkg::ERR_NONE;
		if (over_alarm_q)
			code_d = pps_pkg::ERR_OVER; // [R4]
		else if (dry_alarm_q)
			code_d = pps_pkg::ERR_DRY;
		else if (under_alarm_q)
			code_d = pps_pkg::ERR_UNDER; // [R9]
	end

	// Registers the pump and valve state and the operator outputs.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			base_q                  <= 1'b0;
			off_seen_q              <= 1'b0;
			cyc_cnt_q               <= '0;
			run_q                   <= 2'b00;
			valve_q                 <= 2'b00;
			fault_lamp              <= 1'b0;
			collective_fault_output <= 1'b0;
			dry_run_out_closed      <= 1'b0;
			err_code                <= pps_pkg::ERR_NONE;
			err_reset_avail         <= 1'b0;
		end
		else
		begin
			base_q                  <= base_d;
			off_seen_q              <= off_seen_d;
			cyc_cnt_q               <= cyc_cnt_d;
			run_q                   <= run_d;
			valve_q                 <= valve_d;
			fault_lamp              <= lamp_d;
			collective_fault_output <= lamp_d;
			dry_run_out_closed      <= !dry_alarm_d; // [R16]
			err_code                <= code_d;
			err_reset_avail         <= code_d != pps_pkg::ERR_NONE; // [R20]
		end
	end

	assign pump_run      = run_q;
	assign valve_fresh   = valve_q;
	assign dry_run_count = dry_count_q;
	assign base_pump     = base_q;

endmodule
